// file: asr_pkg.sv
// constants for the asynchronous static memory host controller
// assumes a 50 MHz system clock driving every register
package asr_pkg;
   localparam int ADDR_W = 19;
   localparam int DATA_W = 8;
   localparam int WORDS  = 524288;
   localparam int CNT_W  = 18;
   localparam int SYNC_STAGES = 2;

   localparam int CLK_PERIOD_NS = 20;
   // times as printed, in ns
   localparam int ADDR_ACCESS_NS                 = 70;
   localparam int OUTPUT_ENABLE_ACCESS_DELAY_NS  = 35;
   localparam int WRITE_TO_OUTPUT_FLOAT_DELAY_NS = 25;
   localparam int SELECT_TO_WRITE_END_MIN_NS     = 60;
   localparam int WRITE_PULSE_NS                 = 50;
   localparam int DATA_SETUP_NS                  = 30;
   localparam int DESELECT_TO_RETENTION_DELAY_NS = 0;
   // recovery time in ms
   localparam int RETENTION_RECOVERY_DELAY_MS    = 5;

   function automatic int cyc_up(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   function automatic int max3(input int a, input int b, input int c);
      int m;
      m = (a > b) ? a : b;
      return (m > c) ? m : c;
   endfunction

   localparam int ACC_CYC   = max3(cyc_up(ADDR_ACCESS_NS),
                                   cyc_up(OUTPUT_ENABLE_ACCESS_DELAY_NS), 1);
   localparam int FLOAT_CYC = cyc_up(WRITE_TO_OUTPUT_FLOAT_DELAY_NS);
   localparam int CW_CYC    = cyc_up(SELECT_TO_WRITE_END_MIN_NS);
   localparam int WP_CYC    = cyc_up(WRITE_PULSE_NS);
   localparam int DS_CYC    = cyc_up(DATA_SETUP_NS);
   localparam int RETAIN_CYC = cyc_up(DESELECT_TO_RETENTION_DELAY_NS);

   // read sample waits for the pin value to clear the synchroniser
   localparam int RD_LAST   = ACC_CYC + SYNC_STAGES - 1;
   localparam int FLOAT_LAST = FLOAT_CYC - 1;
   localparam int WR_HOLD_LAST = max3(DS_CYC, CW_CYC - FLOAT_CYC,
                                      WP_CYC - FLOAT_CYC) - 1;
   localparam int RECOVERY_CYC =
      (RETENTION_RECOVERY_DELAY_MS * 1000000 + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;

   typedef enum logic [5:0] {
      ST_IDLE    = 6'h01,
      ST_READ    = 6'h02,
      ST_WFLOAT  = 6'h04,
      ST_WDRIVE  = 6'h08,
      ST_WEND    = 6'h10,
      ST_RETAIN  = 6'h20
   } asr_state_t;
endpackage

// file: asr_sync_if.sv
// carrier between the controller and its data synchroniser
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface asr_sync_if #(parameter int W = 8);
   logic [W-1:0] raw;
   logic [W-1:0] synced;
   modport src  (output raw, input synced);
   modport sink (input raw, output synced);
endinterface
`default_nettype wire

// file: asr_sync.sv
// two-flop synchroniser for the data pins read back from the memory
// assumes raw is an asynchronous pin level
`timescale 1ns/1ps
`default_nettype none
module asr_sync
(
   input  wire logic clk,
   input  wire logic rst,
   asr_sync_if.sink  sif
);
   import asr_pkg::*;

   logic [DATA_W-1:0] meta_q;
   logic [DATA_W-1:0] meta_d;
   logic [DATA_W-1:0] stab_q;
   logic [DATA_W-1:0] stab_d;

   always_comb
   begin
      meta_d = sif.raw;
      stab_d = meta_q;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         meta_q <= 8'h00;
         stab_q <= 8'h00;
      end
      else
      begin
         meta_q <= meta_d;
         stab_q <= stab_d;
      end
   end

   assign sif.synced = stab_q;
endmodule // asr_sync
`default_nettype wire

// file: asr_ctrl.sv
// host-side sequencer for a 512k x 8 asynchronous static memory
// assumes the memory pins are wired straight to this block, 50 MHz clk
// What this block does
// RULE1: 19-bit address, byte data, 512k words
// RULE2: read is select, output enable, rw high
// RULE3: select high idles memory in standby
// RULE4: rw held high through every read
// RULE5: select and rw fall on one edge
// RULE6: select and rw rise on one edge
// RULE7: writes only happen while select is low
// RULE8: drive data only after outputs have floated
// RULE9: coincident rise of both ends the write
// RULE10: select low at least 60 ns per write
// RULE11: read sampled after access times elapse
// RULE12: data drive waits 25 ns after rw falls
// RULE13: select high before retention is signalled
// RULE14: deselected recovery wait after power restore
`timescale 1ns/1ps
`default_nettype none
module asr_ctrl
#(
   parameter int RECOVERY_CYCLES = asr_pkg::RECOVERY_CYC
)
(
   input  wire logic                        clk,
   input  wire logic                        rst,
   input  wire logic                        req_valid,
   output logic                             req_ready,
   input  wire logic                        req_write,
   input  wire logic [asr_pkg::ADDR_W-1:0]  req_addr,
   input  wire logic [asr_pkg::DATA_W-1:0]  req_wdata,
   output logic                             rsp_valid,
   output logic [asr_pkg::DATA_W-1:0]       rsp_rdata,
   input  wire logic                        retention_req,
   output logic                             retention_safe,
   output logic [asr_pkg::ADDR_W-1:0]       word_address,
   output logic                             sram_cs_n,
   output logic                             sram_oe_n,
   output logic                             sram_rw_n,
   input  wire logic [asr_pkg::DATA_W-1:0]  data_bus_i,
   output logic [asr_pkg::DATA_W-1:0]       data_bus_o,
   output logic                             data_bus_oe
);
   import asr_pkg::*;

   asr_state_t          state_q;
   asr_state_t          state_d;
   logic [CNT_W-1:0]    cnt_q;
   logic [CNT_W-1:0]    cnt_d;
   logic [ADDR_W-1:0]   addr_q;
   logic [ADDR_W-1:0]   addr_d;
   logic [DATA_W-1:0]   wdat_q;
   logic [DATA_W-1:0]   wdat_d;
   logic [DATA_W-1:0]   rdat_q;
   logic [DATA_W-1:0]   rdat_d;
   logic                cs_n_q;
   logic                cs_n_d;
   logic                oe_n_q;
   logic                oe_n_d;
   logic                rw_n_q;
   logic                rw_n_d;
   logic                drv_q;
   logic                drv_d;
   logic                rsp_q;
   logic                rsp_d;
   logic                recov_q;
   logic                recov_d;

   asr_sync_if #(.W(DATA_W)) sif ();

   assign sif.raw = data_bus_i;

   asr_sync u_sync
   (
      .clk (clk),
      .rst (rst),
      .sif (sif)
   );

   always_comb
   begin
      state_d = state_q;
      cnt_d   = cnt_q + 18'h00001;
      addr_d  = addr_q;
      wdat_d  = wdat_q;
      rdat_d  = rdat_q;
      // RULE3: default deselected standby
      cs_n_d  = 1'b1;
      oe_n_d  = 1'b1;
      rw_n_d  = 1'b1;
      drv_d   = 1'b0;
      rsp_d   = 1'b0;
      recov_d = recov_q;
      unique case (state_q)
         ST_IDLE:
         begin
            cnt_d = 18'h00000;
            if (recov_q)
            begin
               // RULE14: stay deselected while recovering
               if (cnt_q == CNT_W'(RECOVERY_CYCLES - 1))
                  recov_d = 1'b0;
               else
                  cnt_d = cnt_q + 18'h00001;
            end
            else if (retention_req)
            begin
               state_d = ST_RETAIN;
            end
            else if (req_valid)
            begin
               // RULE1: latch full address and byte
               addr_d = req_addr;
               wdat_d = req_wdata;
               cs_n_d = 1'b0;
               if (req_write)
               begin
                  // RULE5: select and rw fall together
                  rw_n_d  = 1'b0;
                  state_d = ST_WFLOAT;
               end
               else
               begin
                  // RULE2: read with output enable low
                  oe_n_d  = 1'b0;
                  state_d = ST_READ;
               end
            end
         end
         ST_READ:
         begin
            // RULE4: rw stays high in read
            cs_n_d = 1'b0;
            oe_n_d = 1'b0;
            // RULE11: sample after access delay plus sync
            if (cnt_q == CNT_W'(RD_LAST))
            begin
               rdat_d  = sif.synced;
               rsp_d   = 1'b1;
               cs_n_d  = 1'b1;
               oe_n_d  = 1'b1;
               state_d = ST_IDLE;
            end
         end
         ST_WFLOAT:
         begin
            // RULE7: write only with select low
            cs_n_d = 1'b0;
            rw_n_d = 1'b0;
            // RULE12: wait for memory outputs to float
            if (cnt_q == CNT_W'(FLOAT_LAST))
            begin
               // RULE8: no contention on data pins
               drv_d   = 1'b1;
               cnt_d   = 18'h00000;
               state_d = ST_WDRIVE;
            end
         end
         ST_WDRIVE:
         begin
            cs_n_d = 1'b0;
            rw_n_d = 1'b0;
            drv_d  = 1'b1;
            // RULE10: select low long enough
            if (cnt_q == CNT_W'(WR_HOLD_LAST))
            begin
               // RULE6: both rise on one edge
               // RULE9: coincident rise ends the write
               cs_n_d  = 1'b1;
               rw_n_d  = 1'b1;
               state_d = ST_WEND;
            end
         end
         ST_WEND:
         begin
            // one cycle of data hold past the end of write
            rsp_d   = 1'b1;
            state_d = ST_IDLE;
         end
         ST_RETAIN:
         begin
            // RULE13: select already high here
            cnt_d = 18'h00000;
            if (!retention_req)
            begin
               recov_d = 1'b1;
               state_d = ST_IDLE;
            end
         end
         default:
         begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_q <= ST_IDLE;
         cnt_q   <= 18'h00000;
         addr_q  <= 19'h00000;
         wdat_q  <= 8'h00;
         rdat_q  <= 8'h00;
         cs_n_q  <= 1'b1;
         oe_n_q  <= 1'b1;
         rw_n_q  <= 1'b1;
         drv_q   <= 1'b0;
         rsp_q   <= 1'b0;
         recov_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         addr_q  <= addr_d;
         wdat_q  <= wdat_d;
         rdat_q  <= rdat_d;
         cs_n_q  <= cs_n_d;
         oe_n_q  <= oe_n_d;
         rw_n_q  <= rw_n_d;
         drv_q   <= drv_d;
         rsp_q   <= rsp_d;
         recov_q <= recov_d;
      end
   end

   // retention_req is excluded so a late request is not lost
   assign req_ready      = (state_q == ST_IDLE) && !recov_q && !retention_req;
   assign retention_safe = (state_q == ST_RETAIN);
   assign rsp_valid      = rsp_q;
   assign rsp_rdata      = rdat_q;
   assign word_address   = addr_q;
   assign sram_cs_n      = cs_n_q;
   assign sram_oe_n      = oe_n_q;
   assign sram_rw_n      = rw_n_q;
   assign data_bus_o     = wdat_q;
   assign data_bus_oe    = drv_q;
endmodule // asr_ctrl
`default_nettype wire

// file: asr_sram_model.sv
// behavioural 512k x 8 static memory for the host controller bench
// assumes the bench resolves the shared data pins from both drivers
`timescale 1ns/1ps
`default_nettype none
module asr_sram_model
(
   input  wire logic [asr_pkg::ADDR_W-1:0] word_address,
   input  wire logic                       sram_cs_n,
   input  wire logic                       sram_oe_n,
   input  wire logic                       sram_rw_n,
   input  wire logic [asr_pkg::DATA_W-1:0] host_d,
   input  wire logic                       host_oe,
   output logic      [asr_pkg::DATA_W-1:0] dq
);
   import asr_pkg::*;
   logic [DATA_W-1:0] mem [int unsigned];
   logic [DATA_W-1:0] last_q = 8'h00;
   logic [DATA_W-1:0] wd;
   logic [ADDR_W-1:0] wa;
   logic              rd;
   logic              drv = 1'b0;
   logic              wr = 1'b0;
   assign rd = !sram_cs_n && !sram_oe_n && sram_rw_n;
   always @(rd) drv <= #(OUTPUT_ENABLE_ACCESS_DELAY_NS) rd;
   always @(posedge drv) last_q = mem[word_address];
   // floating pins show the inverse so a stale value cannot pass
   assign dq = (rd && drv) ? last_q : ~last_q;
   // capture only while selected and writing
   always @*
      if (!sram_cs_n && !sram_rw_n && host_oe)
      begin
         wa = word_address;
         wd = host_d;
         wr = 1'b1;
      end
   // whichever control rises first ends the write
   always @(posedge sram_cs_n or posedge sram_rw_n)
   begin
      if (wr)
         mem[wa] = wd;
      wr = 1'b0;
   end
endmodule // asr_sram_model
`default_nettype wire

// file: asr_ctrl_checker.sv
// port assertions for the static memory host controller
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module asr_ctrl_checker
#(
   parameter int RECOVERY_CYCLES = 8
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire logic req_write,
   input wire logic rsp_valid,
   input wire logic retention_safe,
   input wire logic sram_cs_n,
   input wire logic sram_oe_n,
   input wire logic sram_rw_n,
   input wire logic data_bus_oe
);
   logic [19:0] gap_q;
   logic [19:0] gap_d;
   logic        take;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   assign take = req_valid && req_ready;
   always_comb gap_d = retention_safe ? 20'h0 : gap_q + {19'h0, ~&gap_q};
   // reset asks no recovery wait, so start saturated
   always_ff @(posedge clk) gap_q <= rst ? 20'hfffff : gap_d;
   rd_rw_high_a:
      assert property (!sram_cs_n && !sram_oe_n |-> sram_rw_n)
      else $error("rw low during a read");
   float_first_a:
      assert property ($rose(data_bus_oe) |-> !$past(sram_rw_n, 2))
      else $error("data driven too soon after rw fell");
   no_clash_a:
      assert property (data_bus_oe |-> sram_oe_n)
      else $error("output enable low while driving");
   fall_pair_a:
      assert property ($fell(sram_rw_n) |-> $fell(sram_cs_n))
      else $error("rw fell apart from select");
   rise_pair_a:
      assert property ($rose(sram_rw_n) |-> $rose(sram_cs_n))
      else $error("rw rose apart from select");
   sel_width_a:
      assert property ($fell(sram_cs_n) && !sram_rw_n |-> !sram_cs_n [*3])
      else $error("select pulse too short");
   retain_desel_a:
      assert property (retention_safe |-> sram_cs_n)
      else $error("selected while retention allowed");
   recover_wait_a:
      assert property (req_ready |-> gap_q >= RECOVERY_CYCLES)
      else $error("ready before recovery elapsed");
   idle_standby_a:
      assert property (req_ready |-> sram_cs_n && !data_bus_oe)
      else $error("memory selected while idle");
   read_walk_a:
      assert property (take && !req_write |=> (!sram_cs_n && !sram_oe_n)
         [*6] ##1 (sram_cs_n && rsp_valid))
      else $error("read strobe timing wrong");
   write_walk_a:
      assert property (take && req_write |=> (!sram_cs_n && !sram_rw_n)
         [*4] ##1 (sram_rw_n && data_bus_oe) ##1 (rsp_valid && !data_bus_oe))
      else $error("write strobe timing wrong");
   cover property (take && req_write);
   cover property (take && !req_write);
   cover property ($fell(retention_safe));
endmodule // asr_ctrl_checker
bind asr_ctrl asr_ctrl_checker #(.RECOVERY_CYCLES(RECOVERY_CYCLES)) u_chk
(
   .clk            (clk),
   .rst            (rst),
   .req_valid      (req_valid),
   .req_ready      (req_ready),
   .req_write      (req_write),
   .rsp_valid      (rsp_valid),
   .retention_safe (retention_safe),
   .sram_cs_n      (sram_cs_n),
   .sram_oe_n      (sram_oe_n),
   .sram_rw_n      (sram_rw_n),
   .data_bus_oe    (data_bus_oe)
);
`default_nettype wire

// file: asr_ctrl_bench.sv
// self-checking bench for the static memory host controller
// assumes the memory model and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module asr_ctrl_bench;
   import asr_pkg::*;
   localparam int RECOV = 8;
   // cycles from the take edge until the response shows
   localparam int RD_LAT = 6;
   localparam int WR_LAT = 5;
   typedef struct packed {
      logic              w;
      logic [ADDR_W-1:0] a;
      logic [DATA_W-1:0] d;
      logic [DATA_W-1:0] e;
   } asr_row_t;
   // no read expects the inverse of the byte read before it, since the
   // model shows that inverse on floating pins and a stale sample would pass
   asr_row_t rows [6] = '{
      '{1'h1, 19'h00000, 8'h96, 8'h00}, '{1'h1, 19'h7ffff, 8'h5a, 8'h00},
      '{1'h0, 19'h7ffff, 8'h00, 8'h5a}, '{1'h0, 19'h00000, 8'h00, 8'h96},
      '{1'h1, 19'h00000, 8'h3c, 8'h00}, '{1'h0, 19'h00000, 8'h00, 8'h3c}};
   logic              clk = 1'b0;
   logic              rst = 1'b1;
   logic              req_valid = 1'b0;
   logic              req_write = 1'b0;
   logic [ADDR_W-1:0] req_addr = 19'h0;
   logic [DATA_W-1:0] req_wdata = 8'h0;
   logic              retention_req = 1'b0;
   logic              req_ready, rsp_valid, retention_safe;
   logic              sram_cs_n, sram_oe_n, sram_rw_n, data_bus_oe;
   logic [DATA_W-1:0] rsp_rdata, data_bus_o, mdl_q;
   logic [ADDR_W-1:0] word_address;
   wire  [DATA_W-1:0] data_bus_i;
   int                mismatches = 0;
   int                cmp_count = 0;
   always #10 clk = ~clk;
   assign data_bus_i = data_bus_oe ? data_bus_o : mdl_q;
   asr_ctrl #(.RECOVERY_CYCLES(RECOV)) dut
   (
      .clk            (clk),
      .rst            (rst),
      .req_valid      (req_valid),
      .req_ready      (req_ready),
      .req_write      (req_write),
      .req_addr       (req_addr),
      .req_wdata      (req_wdata),
      .rsp_valid      (rsp_valid),
      .rsp_rdata      (rsp_rdata),
      .retention_req  (retention_req),
      .retention_safe (retention_safe),
      .word_address   (word_address),
      .sram_cs_n      (sram_cs_n),
      .sram_oe_n      (sram_oe_n),
      .sram_rw_n      (sram_rw_n),
      .data_bus_i     (data_bus_i),
      .data_bus_o     (data_bus_o),
      .data_bus_oe    (data_bus_oe)
   );
   asr_sram_model mdl (.word_address(word_address), .sram_cs_n(sram_cs_n),
      .sram_oe_n(sram_oe_n), .sram_rw_n(sram_rw_n), .host_d(data_bus_o),
      .host_oe(data_bus_oe), .dq(mdl_q));
   task automatic chk(input string       nm,
                      input logic [31:0] s,
                      input logic [31:0] x);
      cmp_count++;
      if (s !== x)
      begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", nm, x, s);
      end
   endtask
   task automatic op(input asr_row_t r);
      int n;
      @(posedge clk) #1;
      req_valid = 1'b1;
      req_write = r.w;
      req_addr = r.a;
      req_wdata = r.d;
      n = 0;
      while (req_ready !== 1'b1 && n < 40)
      begin
         @(posedge clk) #1;
         n++;
      end
      @(posedge clk) #1;
      req_valid = 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 40)
      begin
         @(posedge clk) #1;
         n++;
      end
      chk("latency", n, r.w ? WR_LAT : RD_LAT);
      if (!r.w)
         chk("read byte", rsp_rdata, r.e);
   endtask
   task automatic close_out;
      $display("compares %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // about 80 cycles are needed; allow fifty times that
   initial
   begin
      #80000;
      mismatches++;
      close_out;
   end
   initial
   begin
      int n;
      repeat (3) @(posedge clk);
      #1;
      rst = 1'b0;
      chk("idle pins",
          {sram_cs_n, sram_oe_n, sram_rw_n, data_bus_oe, req_ready},
          32'h1d);
      $display("test reset done");
      foreach (rows[i]) op(rows[i]);
      $display("test table done");
      // reset in the middle of a write must leave the pins idle
      req_valid = 1'b1;
      req_write = 1'b1;
      req_addr = 19'h12345;
      repeat (3) @(posedge clk) #1;
      rst = 1'b1;
      req_valid = 1'b0;
      @(posedge clk) #1;
      rst = 1'b0;
      chk("pins after abort",
          {sram_cs_n, sram_rw_n, data_bus_oe}, 32'h6);
      op('{1'h0, 19'h00000, 8'h00, 8'h3c});
      $display("test abort done");
      retention_req = 1'b1;
      repeat (2) @(posedge clk) #1;
      chk("retention", {retention_safe, sram_cs_n, req_ready}, 32'h6);
      retention_req = 1'b0;
      n = 0;
      while (req_ready !== 1'b1 && n < 40)
      begin
         @(posedge clk) #1;
         n++;
      end
      // a ready that never returns must not pass as a long wait
      chk("recovery wait", n >= RECOV && n < 40, 32'h1);
      op('{1'h0, 19'h7ffff, 8'h00, 8'h5a});
      $display("test retention done");
      close_out;
   end
endmodule // asr_ctrl_bench
`default_nettype wire
